/* File: colour_seq_pkg.sv */
/*
 Shared constants and types for the colour channel sequencer: register
 addresses, field positions, reset values, colour codes and offset steps.
 Assumes a single clock domain and the three-wire configuration port.
*/
package colour_seq_pkg;
   // Register addresses carried in the three address bits.
   localparam logic [2:0] ADDR_COLOUR_MODE_SELECT = 3'h0;
   localparam logic [2:0] ADDR_RED_OFFSET_TRIM = 3'h1;
   localparam logic [2:0] ADDR_GREEN_OFFSET_TRIM = 3'h2;
   localparam logic [2:0] ADDR_BLUE_OFFSET_TRIM = 3'h3;
   // Field positions.
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 2;
   localparam int POLARITY_BIT = 4;
   localparam int CDS_BIT = 5;
   localparam int SIGN_BIT = 5;
   localparam int MAG_MSB = 4;
   // Frame layout: three address bits then six data bits.
   localparam int ADDR_BITS = 3;
   localparam int DATA_BITS = 6;
   localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
   // Reset values.
   localparam logic [5:0] MODE_RESET = 6'h00;
   localparam logic [5:0] TRIM_RESET = 6'h00;
   // Output codes per magnitude step for the two converter widths.
   localparam logic [10:0] STEP_10BIT = 11'h005;
   localparam logic [10:0] STEP_12BIT = 11'h014;
   localparam int OFFSET_WIDTH = 11;
   // Colour mode codes.
   localparam logic [2:0] MODE_LINE_RATE = 3'h0;
   localparam logic [2:0] MODE_PIXEL_RATE = 3'h1;
   localparam logic [2:0] MODE_MONO_RED = 3'h3;
   localparam logic [2:0] MODE_MONO_GREEN = 3'h4;
   localparam logic [2:0] MODE_MONO_BLUE = 3'h5;
   localparam logic [2:0] MODE_BAYER = 3'h6;
   localparam logic [2:0] MODE_GREEN_STRIPE = 3'h7;
   // Colour codes used both for input selection and gain/offset set.
   typedef enum logic [1:0]
   {
      COL_RED = 2'h0,
      COL_GREEN = 2'h1,
      COL_BLUE = 2'h2
   } colour_type;
endpackage : colour_seq_pkg

/* File: serial_config_rx.sv */
/*
 Three-wire configuration receiver: shifts address and data bits in on the
 serial clock and hands out one write when the latch strobe rises.
 Assumes all three pins are asynchronous to clock and slow next to it.
*/
`timescale 1ns/1ps
module serial_config_rx
   import colour_seq_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic serialClock,
   input wire logic latchStrobe,
   input wire logic serial_config_in,
   output logic writeValid,
   output logic [2:0] writeAddr,
   output logic [5:0] writeData
);
   logic [1:0] sclkSync_r;
   logic [1:0] latchSync_r;
   logic [1:0] dataSync_r;
   logic sclkPrev_r;
   logic latchPrev_r;
   logic [FRAME_BITS-1:0] shift_r;
   logic writeValid_r;
   logic [FRAME_BITS-1:0] frame_r;

   ////////////////////////////////////////////////////////////////////////
   // Two flip-flops on every pin before any logic looks at it.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         sclkSync_r <= 2'h0;
         latchSync_r <= 2'h0;
         dataSync_r <= 2'h0;
         sclkPrev_r <= 1'b0;
         latchPrev_r <= 1'b0;
      end
      else
      begin
         sclkSync_r <= {sclkSync_r[0], serialClock};
         latchSync_r <= {latchSync_r[0], latchStrobe};
         dataSync_r <= {dataSync_r[0], serial_config_in};
         sclkPrev_r <= sclkSync_r[1];
         latchPrev_r <= latchSync_r[1];
      end
   end

   // Shift only while latch is low, so a raised latch freezes the frame.
   wire sclkRise = sclkSync_r[1] & ~sclkPrev_r;
   wire latchRise = latchSync_r[1] & ~latchPrev_r;
   wire shiftNow = sclkRise & ~latchSync_r[1];

   ////////////////////////////////////////////////////////////////////////
   // Most significant bit arrives first, so it ends up at the top.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         shift_r <= '0;
         frame_r <= '0;
         writeValid_r <= 1'b0;
      end
      else
      begin
         if (shiftNow)
            shift_r <= {shift_r[FRAME_BITS-2:0], dataSync_r[1]};
         writeValid_r <= latchRise; // RULE15
         if (latchRise)
            frame_r <= shift_r; // RULE15
      end
   end

   assign writeValid = writeValid_r;
   assign writeAddr = frame_r[FRAME_BITS-1:DATA_BITS];
   assign writeData = frame_r[DATA_BITS-1:0];
endmodule : serial_config_rx

/* File: colour_channel_sequencer.sv */
/*
 Colour channel sequencer: picks the sensor input and the gain/offset set
 per pixel from the colour mode, and decodes the signed offset trims.
 Assumes pixel and line strobes and the serial port arrive from pins
 asynchronous to clock and much slower than it.
// Function
// RULE1 - Mode 000 steps input and gain set together red, green, blue once per line.
// RULE2 - Any write to the mode register restarts the sequence at its first-line pattern.
// RULE3 - Mode 001 holds the blue input and rotates the gain set every pixel.
// RULE4 - Mode 011 holds the red input and red settings.
// RULE5 - Mode 100 holds the green input and green settings.
// RULE6 - Mode 101 holds the blue input and blue settings.
// RULE7 - Bayer mode 110 holds the blue input and switches gain sets per pixel.
// RULE8 - Bayer uses green/red on the first line, blue/green on the second, then repeats.
// RULE9 - Green-stripe mode 111 holds the blue input and switches gain sets per pixel.
// RULE10 - Green stripe repeats red, green, blue, green on every line.
// RULE11 - The narrow variant gives five output codes per magnitude step.
// RULE12 - The wide variant gives twenty output codes per magnitude step.
// RULE13 - Trim bit 5 is the sign, set meaning negative, and zero magnitude is zero either way.
// RULE14 - The host shifts three address then six data bits, first bit most significant.
// RULE15 - On the latch rising the last nine bits program the addressed register.
// RULE16 - The host never uses the reserved mode 010.
// RULE17 - The line counter steps on each line strobe and the pixel counter on each sample clock.
*/
`timescale 1ns/1ps
module colour_channel_sequencer
   import colour_seq_pkg::*;
#(
   parameter bit WIDE_VARIANT = 1'b0
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic pixel_sample_clock,
   input wire logic line_start_strobe,
   input wire logic serialClock,
   input wire logic latchStrobe,
   input wire logic serial_config_in,
   output logic [1:0] inputSelect,
   output logic [1:0] gainOffsetSet,
   output logic signed [OFFSET_WIDTH-1:0] activeOffset,
   output logic signed [OFFSET_WIDTH-1:0] redOffset,
   output logic signed [OFFSET_WIDTH-1:0] greenOffset,
   output logic signed [OFFSET_WIDTH-1:0] blueOffset,
   output logic cdsDisable,
   output logic polarityPositive
);
   localparam logic [10:0] STEP = WIDE_VARIANT ? STEP_12BIT : STEP_10BIT; // RULE11 RULE12

   logic writeValid;
   logic [2:0] writeAddr;
   logic [5:0] writeData;
   logic [5:0] colour_mode_select_r;
   logic [5:0] trim_r [3];
   logic [1:0] pixSync_r;
   logic [1:0] lineSync_r;
   logic pixPrev_r;
   logic linePrev_r;
   logic [1:0] line3_r;
   logic lineOdd_r;
   logic [1:0] pix3_r;
   logic [1:0] pix4_r;
   logic restartPending_r;
   colour_type muxSel_r;
   colour_type gainSel_r;
   colour_type muxSel_nxt;
   colour_type gainSel_nxt;
   logic signed [OFFSET_WIDTH-1:0] offsetVal [3];
   logic signed [OFFSET_WIDTH-1:0] activeOffset_r;

   ////////////////////////////////////////////////////////////////////////
   // Configuration port receiver.
   serial_config_rx rx
   (
      .clock(clock),
      .reset(reset),
      .serialClock(serialClock),
      .latchStrobe(latchStrobe),
      .serial_config_in(serial_config_in),
      .writeValid(writeValid),
      .writeAddr(writeAddr),
      .writeData(writeData)
   );

   // Register decode; gain and test addresses land nowhere here.
   wire modeWrite = writeValid && (writeAddr == ADDR_COLOUR_MODE_SELECT);
   wire [2:0] mode = colour_mode_select_r[MODE_MSB:MODE_LSB];

   // The mode register and the three trims.
   always_ff @(posedge clock)
   begin
      if (reset)
         colour_mode_select_r <= MODE_RESET;
      else if (modeWrite)
         colour_mode_select_r <= writeData; // RULE15
   end

   genvar c;
   generate
      for (c = 0; c < 3; c++)
      begin : g_trim
         wire trimWrite = writeValid && (writeAddr == ADDR_RED_OFFSET_TRIM + 3'(c));
         wire [10:0] magnitude = 11'(trim_r[c][MAG_MSB:0]) * STEP; // RULE11 RULE12
         always_ff @(posedge clock)
         begin
            if (reset)
               trim_r[c] <= TRIM_RESET;
            else if (trimWrite)
               trim_r[c] <= writeData; // RULE15
         end
         // Negating zero is still zero, so both zero codes give no offset.
         assign offsetVal[c] = trim_r[c][SIGN_BIT] ? -$signed(magnitude) : $signed(magnitude); // RULE13
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Strobe pins pass two flip-flops; edges are taken after the second.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pixSync_r <= 2'h0;
         lineSync_r <= 2'h0;
         pixPrev_r <= 1'b0;
         linePrev_r <= 1'b0;
      end
      else
      begin
         pixSync_r <= {pixSync_r[0], pixel_sample_clock};
         lineSync_r <= {lineSync_r[0], line_start_strobe};
         pixPrev_r <= pixSync_r[1];
         linePrev_r <= lineSync_r[1];
      end
   end

   wire pixelEdge = pixSync_r[1] & ~pixPrev_r;
   wire lineEdge = lineSync_r[1] & ~linePrev_r;

   ////////////////////////////////////////////////////////////////////////
   // Line and pixel counters. A mode write zeroes them and holds the line
   // count at zero over the next line strobe, so that line is the first.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         line3_r <= 2'h0;
         lineOdd_r <= 1'b0;
         pix3_r <= 2'h0;
         pix4_r <= 2'h0;
         restartPending_r <= 1'b0;
      end
      else if (modeWrite)
      begin
         line3_r <= 2'h0; // RULE2
         lineOdd_r <= 1'b0; // RULE2
         pix3_r <= 2'h0; // RULE2
         pix4_r <= 2'h0; // RULE2
         restartPending_r <= 1'b1; // RULE2
      end
      else if (lineEdge)
      begin
         pix3_r <= 2'h0;
         pix4_r <= 2'h0;
         restartPending_r <= 1'b0;
         if (!restartPending_r)
         begin
            line3_r <= (line3_r == 2'h2) ? 2'h0 : line3_r + 2'h1; // RULE17
            lineOdd_r <= ~lineOdd_r; // RULE17
         end
      end
      else if (pixelEdge)
      begin
         pix3_r <= (pix3_r == 2'h2) ? 2'h0 : pix3_r + 2'h1; // RULE17
         pix4_r <= pix4_r + 2'h1; // RULE17
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pattern tables for the line-rate and pixel-rate modes.
   wire colour_type rotation = (pix3_r == 2'h0) ? COL_BLUE : ((pix3_r == 2'h1) ? COL_RED : COL_GREEN); // RULE3
   wire colour_type bayerOdd = pix4_r[0] ? COL_GREEN : COL_BLUE; // RULE8
   wire colour_type bayerEven = pix4_r[0] ? COL_RED : COL_GREEN; // RULE8
   wire colour_type bayer = lineOdd_r ? bayerOdd : bayerEven; // RULE8
   wire colour_type stripeOdd = pix4_r[1] ? COL_BLUE : COL_RED; // RULE10
   wire colour_type stripe = pix4_r[0] ? COL_GREEN : stripeOdd; // RULE10
   wire colour_type lineColour = colour_type'(line3_r); // RULE1

   // Selection per mode; the reserved code falls back to red.
   always_comb
   begin
      muxSel_nxt = COL_RED;
      gainSel_nxt = COL_RED;
      unique case (mode)
         MODE_LINE_RATE:
         begin
            muxSel_nxt = lineColour; // RULE1
            gainSel_nxt = lineColour; // RULE1
         end
         MODE_PIXEL_RATE:
         begin
            muxSel_nxt = COL_BLUE; // RULE3
            gainSel_nxt = rotation; // RULE3
         end
         MODE_MONO_RED:
         begin
            muxSel_nxt = COL_RED; // RULE4
            gainSel_nxt = COL_RED; // RULE4
         end
         MODE_MONO_GREEN:
         begin
            muxSel_nxt = COL_GREEN; // RULE5
            gainSel_nxt = COL_GREEN; // RULE5
         end
         MODE_MONO_BLUE:
         begin
            muxSel_nxt = COL_BLUE; // RULE6
            gainSel_nxt = COL_BLUE; // RULE6
         end
         MODE_BAYER:
         begin
            muxSel_nxt = COL_BLUE; // RULE7
            gainSel_nxt = bayer; // RULE7
         end
         MODE_GREEN_STRIPE:
         begin
            muxSel_nxt = COL_BLUE; // RULE9
            gainSel_nxt = stripe; // RULE9
         end
         default:
         begin
            muxSel_nxt = COL_RED; // RULE16
            gainSel_nxt = COL_RED;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Selection and active offset outputs are registered so the analog side sees clean levels.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         muxSel_r <= COL_RED;
         gainSel_r <= COL_RED;
         activeOffset_r <= '0;
      end
      else
      begin
         muxSel_r <= muxSel_nxt;
         gainSel_r <= gainSel_nxt;
         activeOffset_r <= offsetVal[gainSel_nxt];
      end
   end

   assign inputSelect = muxSel_r;
   assign gainOffsetSet = gainSel_r;
   assign activeOffset = activeOffset_r;
   assign redOffset = offsetVal[0];
   assign greenOffset = offsetVal[1];
   assign blueOffset = offsetVal[2];
   assign cdsDisable = colour_mode_select_r[CDS_BIT];
   assign polarityPositive = colour_mode_select_r[POLARITY_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Checks on sequencing and offset decode.
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   line_rate_lock_a: assert property ((mode == MODE_LINE_RATE) && !modeWrite |=> inputSelect == gainOffsetSet) // RULE1
      else $error("Line rate mode split input and gain set.");
   // A pixel edge right after the write is legal and may already step the phase.
   restart_first_a: assert property (modeWrite ##1 !lineEdge && !modeWrite // RULE2
      |=> line3_r == 2'h0 && pix4_r == {1'b0, $past(pixelEdge)})
      else $error("Mode write did not restart the sequence.");
   first_line_hold_a: assert property (restartPending_r && lineEdge && !modeWrite // RULE2 RULE8
      |=> line3_r == 2'h0 && !lineOdd_r && !restartPending_r)
      else $error("First line after a mode write moved the line count.");
   pixel_blue_a: assert property ($past(mode) == MODE_PIXEL_RATE && mode == MODE_PIXEL_RATE |-> inputSelect == COL_BLUE) // RULE3
      else $error("Pixel rate mode left the blue input.");
   rotate_step_a: assert property (mode == MODE_PIXEL_RATE && pixelEdge && !lineEdge && !modeWrite // RULE3
      && pix3_r == 2'h0 ##1 mode == MODE_PIXEL_RATE |=> gainOffsetSet == COL_RED)
      else $error("Pixel rotation did not go from blue to red.");
   mono_red_a: assert property ($past(mode) == MODE_MONO_RED && mode == MODE_MONO_RED // RULE4
      |-> inputSelect == COL_RED && gainOffsetSet == COL_RED)
      else $error("Red monochrome selection wrong.");
   mono_green_a: assert property ($past(mode) == MODE_MONO_GREEN && mode == MODE_MONO_GREEN // RULE5
      |-> inputSelect == COL_GREEN && gainOffsetSet == COL_GREEN)
      else $error("Green monochrome selection wrong.");
   mono_blue_a: assert property ($past(mode) == MODE_MONO_BLUE && mode == MODE_MONO_BLUE // RULE6
      |-> inputSelect == COL_BLUE && gainOffsetSet == COL_BLUE)
      else $error("Blue monochrome selection wrong.");
   bayer_pair_a: assert property ($past(mode) == MODE_BAYER && mode == MODE_BAYER // RULE7 RULE8
      |-> inputSelect == COL_BLUE && gainOffsetSet == ($past(lineOdd_r) ? ($past(pix4_r[0]) ? COL_GREEN : COL_BLUE)
      : ($past(pix4_r[0]) ? COL_RED : COL_GREEN)))
      else $error("Bayer pattern wrong.");
   stripe_order_a: assert property ($past(mode) == MODE_GREEN_STRIPE && mode == MODE_GREEN_STRIPE // RULE9 RULE10
      && $past(pix4_r) == 2'h2 |-> inputSelect == COL_BLUE && gainOffsetSet == COL_BLUE)
      else $error("Green stripe third pixel not blue.");
   offset_sign_a: assert property (redOffset == (trim_r[0][SIGN_BIT] // RULE11 RULE12 RULE13
      ? -$signed(11'(trim_r[0][MAG_MSB:0]) * STEP) : $signed(11'(trim_r[0][MAG_MSB:0]) * STEP)))
      else $error("Red offset decode wrong.");
   // A trim write moves the decoded offsets one clock before the registered copy.
   active_offset_a: assert property (!$past(writeValid) |-> activeOffset == offsetVal[gainOffsetSet]) // RULE11 RULE12
      else $error("Active offset does not match the selected set.");
endmodule : colour_channel_sequencer

/* File: sensor_host_model.sv */
/*
 Host and sensor timing model: drives the three-wire configuration port and
 the pixel and line strobes the way a scanner controller would.
 Assumes clock is the system clock of the block and pins move 1 ns after it.
*/
`timescale 1ns/1ps
module sensor_host_model
(
   input wire logic clock,
   output logic serialClock,
   output logic latchStrobe,
   output logic serial_config_in,
   output logic pixel_sample_clock,
   output logic line_start_strobe
);
   ////////////////////////////////////////////////////////////////////////
   // Every pin starts low; the block must not see an edge before reset ends.
   initial
   begin
      serialClock = 1'b0;
      latchStrobe = 1'b0;
      serial_config_in = 1'b0;
      pixel_sample_clock = 1'b0;
      line_start_strobe = 1'b0;
   end

   // Holds the pins for n clocks, then lands just after an edge.
   task automatic hold_clocks(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : hold_clocks

   ////////////////////////////////////////////////////////////////////////
   // One frame, three address then six data bits, first bit most significant.
   // Four clocks per level keeps clear of the three-clock synchroniser limit.
   task automatic write_reg(input logic [2:0] addr, input logic [5:0] data);
      logic [8:0] frame;
      frame = {addr, data};
      for (int i = 8; i >= 0; i--)
      begin
         serial_config_in = frame[i];
         hold_clocks(4);
         serialClock = 1'b1;
         hold_clocks(4);
         serialClock = 1'b0;
      end
      latchStrobe = 1'b1;
      hold_clocks(8);
      serial_config_in = ~frame[0];
      latchStrobe = 1'b0;
      hold_clocks(4);
   endtask : write_reg

   // A pixel or line strobe; the block's outputs have settled when it returns.
   task automatic strobe(input bit isLine);
      if (isLine)
         line_start_strobe = 1'b1;
      else
         pixel_sample_clock = 1'b1;
      hold_clocks(4);
      line_start_strobe = 1'b0;
      pixel_sample_clock = 1'b0;
      hold_clocks(4);
   endtask : strobe
endmodule : sensor_host_model

/* File: colour_channel_sequencer_tb.sv */
/*
 Self-checking bench for the colour channel sequencer: narrow and wide
 variants side by side, both fed by one host model.
 Assumes the design's two-stage pin synchronisers and registered outputs.
*/
`timescale 1ns/1ps
module colour_channel_sequencer_tb
   import colour_seq_pkg::*;
;
   logic clock;
   logic reset;
   logic serialClock, latchStrobe, serial_config_in, pixel_sample_clock, line_start_strobe;
   logic [1:0] inputSelect;
   logic [1:0] gainOffsetSet;
   logic signed [OFFSET_WIDTH-1:0] activeOffset, redOffset, greenOffset, blueOffset;
   logic signed [OFFSET_WIDTH-1:0] wideRed, wideGreen;
   logic cdsDisable, polarityPositive;
   int fails = 0;
   int numChecks = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock at 50 MHz and a three-cycle reset.
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   sensor_host_model host_u (.clock(clock), .serialClock(serialClock), .latchStrobe(latchStrobe),
      .serial_config_in(serial_config_in), .pixel_sample_clock(pixel_sample_clock),
      .line_start_strobe(line_start_strobe));

   colour_channel_sequencer #(.WIDE_VARIANT(1'b0)) dut_u (.clock(clock), .reset(reset),
      .pixel_sample_clock(pixel_sample_clock), .line_start_strobe(line_start_strobe),
      .serialClock(serialClock), .latchStrobe(latchStrobe), .serial_config_in(serial_config_in),
      .inputSelect(inputSelect), .gainOffsetSet(gainOffsetSet), .activeOffset(activeOffset),
      .redOffset(redOffset), .greenOffset(greenOffset), .blueOffset(blueOffset),
      .cdsDisable(cdsDisable), .polarityPositive(polarityPositive));

   // The wide variant only matters for its offset scaling.
   colour_channel_sequencer #(.WIDE_VARIANT(1'b1)) wide_u (.clock(clock), .reset(reset),
      .pixel_sample_clock(pixel_sample_clock), .line_start_strobe(line_start_strobe),
      .serialClock(serialClock), .latchStrobe(latchStrobe), .serial_config_in(serial_config_in),
      .inputSelect(), .gainOffsetSet(), .activeOffset(), .redOffset(wideRed),
      .greenOffset(wideGreen), .blueOffset(), .cdsDisable(), .polarityPositive());

   ////////////////////////////////////////////////////////////////////////
   // Compare tasks, one per width of result.
   task automatic check2(input string name, input logic [1:0] exp, input logic [1:0] got);
      numChecks++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check2

   task automatic check11(input string name, input logic [10:0] exp, input logic [10:0] got);
      numChecks++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check11

   // A line strobe then four pixels; pat holds five expected sets, oldest first.
   task automatic line_pattern(input logic [1:0] inExp, input logic [9:0] pat);
      for (int i = 0; i < 5; i++)
      begin
         host_u.strobe(i == 0);
         check2("inputSelect", inExp, inputSelect);
         check2("gainOffsetSet", pat[9-2*i -: 2], gainOffsetSet);
      end
   endtask : line_pattern

   task automatic conclude();
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // A run takes under two thousand clocks; a hang is cut at twenty thousand.
   initial
   begin
      repeat (20000) @(posedge clock);
      fails++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence. Mode 010 is never written since it is reserved.
   initial
   begin
      reset = 1'b1;
      repeat (3) @(posedge clock);
      #1;
      reset = 1'b0;
      host_u.write_reg(ADDR_COLOUR_MODE_SELECT, 6'h00);
      check2("firstLine", COL_RED, gainOffsetSet);
      line_pattern(COL_RED, {5{COL_RED}});
      line_pattern(COL_GREEN, {5{COL_GREEN}});
      host_u.write_reg(ADDR_COLOUR_MODE_SELECT, 6'h00);
      check2("restart", COL_RED, inputSelect);
      line_pattern(COL_RED, {5{COL_RED}});
      line_pattern(COL_GREEN, {5{COL_GREEN}});
      line_pattern(COL_BLUE, {5{COL_BLUE}});
      line_pattern(COL_RED, {5{COL_RED}});
      host_u.write_reg(ADDR_COLOUR_MODE_SELECT, {3'h0, MODE_PIXEL_RATE});
      line_pattern(COL_BLUE, {COL_BLUE, COL_RED, COL_GREEN, COL_BLUE, COL_RED});
      host_u.write_reg(ADDR_COLOUR_MODE_SELECT, {3'h0, MODE_BAYER});
      line_pattern(COL_BLUE, {COL_GREEN, COL_RED, COL_GREEN, COL_RED, COL_GREEN});
      line_pattern(COL_BLUE, {COL_BLUE, COL_GREEN, COL_BLUE, COL_GREEN, COL_BLUE});
      line_pattern(COL_BLUE, {COL_GREEN, COL_RED, COL_GREEN, COL_RED, COL_GREEN});
      host_u.write_reg(ADDR_COLOUR_MODE_SELECT, {3'h0, MODE_GREEN_STRIPE});
      line_pattern(COL_BLUE, {COL_RED, COL_GREEN, COL_BLUE, COL_GREEN, COL_RED});
      line_pattern(COL_BLUE, {COL_RED, COL_GREEN, COL_BLUE, COL_GREEN, COL_RED});
      // Trims: +155 red, -155 green, negative zero blue.
      host_u.write_reg(ADDR_RED_OFFSET_TRIM, 6'h1F);
      host_u.write_reg(ADDR_GREEN_OFFSET_TRIM, 6'h3F);
      host_u.write_reg(ADDR_BLUE_OFFSET_TRIM, 6'h20);
      check11("redOffset", 11'h09B, redOffset);
      check11("greenOffset", 11'h765, greenOffset);
      check11("blueOffset", 11'h000, blueOffset);
      check11("wideRed", 11'h26C, wideRed);
      check11("wideGreen", 11'h594, wideGreen);
      // Monochrome modes, each with the offset of its own colour active.
      for (int m = 0; m < 3; m++)
      begin
         host_u.write_reg(ADDR_COLOUR_MODE_SELECT, {3'h0, 3'(MODE_MONO_RED + m)});
         line_pattern(2'(m), {5{2'(m)}});
         check11("activeOffset", (m == 0) ? 11'h09B : (m == 1) ? 11'h765 : 11'h000, activeOffset);
      end
      host_u.write_reg(ADDR_RED_OFFSET_TRIM, 6'h01);
      check11("smallRed", 11'h005, redOffset);
      check11("wideSmallRed", 11'h014, wideRed);
      host_u.write_reg(ADDR_COLOUR_MODE_SELECT, {3'h6, MODE_MONO_BLUE});
      host_u.write_reg(3'h4, 6'h3F);
      check2("cdsPolarity", 2'h3, {cdsDisable, polarityPositive});
      check2("unmapped", COL_BLUE, inputSelect);
      check11("unmappedRed", 11'h005, redOffset);
      conclude();
   end
endmodule : colour_channel_sequencer_tb
